// ==== rtl/tsd_pkg.sv ====
// package: offsets and layouts of the trim and swap delay registers, reset values of the swap delay registers
package tsd_pkg;
   // ----------------------------------------------------------------
   // register indices (printed offsets are not all multiples of four)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_CORE_GAIN_TRIM  = 10'h07a;
   localparam logic [9:0] IDX_REFERENCE_TRIM  = 10'h07c;
   localparam logic [9:0] IDX_TERM_TRIM_A     = 10'h07e;
   localparam logic [9:0] IDX_TERM_TRIM_B     = 10'h07f;
   localparam logic [9:0] IDX_TERM_TRIM_C     = 10'h080;
   localparam logic [9:0] IDX_TERM_TRIM_D     = 10'h081;
   localparam logic [9:0] IDX_SWAP_OVERLAP    = 10'h09a;
   localparam logic [9:0] IDX_OUTPUT_SEL_DLY  = 10'h09b;
   localparam int         NUM_INPUTS          = 4;
   // ----------------------------------------------------------------
   // field widths and reset values
   // ----------------------------------------------------------------
   localparam int         REF_TRIM_W          = 4;
   localparam int         DLY_W               = 5;
   localparam logic [4:0] SWAP_OVERLAP_RST    = 5'h08;
   localparam logic [4:0] OUTPUT_SEL_DLY_RST  = 5'h07;
   localparam logic [6:0] OVERLAP_BASE_CYC    = 7'h04;
   // ----------------------------------------------------------------
   // factory fuse values carried together
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                  gain;
      logic [3:0]                  reference;
      logic [NUM_INPUTS-1:0][7:0]  termination;
   } tsd_fuse_t;
   // wishbone request as seen by the slave
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [11:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } tsd_wb_req_t;
endpackage : tsd_pkg

// ==== rtl/tsd_trim_and_swap_delay_regs.sv ====
// trim and swap delay register bank behind a classic wishbone slave
//
// Contract
// - trims reset from fuses; software reads, overwrites
// - 8-bit gain trim drives all cores
// - 4-bit reference trim in low bits
// - four 8-bit termination trims, one per input
// - swap overlap lasts four plus twice setting
// - overlap delay 5-bit, 0..31, reset 0x08
// - select delayed by setting, only during swaps
// - select delay 5-bit, 0..31, reset 0x07
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
module tsd_trim_and_swap_delay_regs
   import tsd_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire tsd_wb_req_t              wb_req_i,
   output logic                          wb_ack_o,
   output logic [31:0]                   wb_dat_o,
   input  wire tsd_fuse_t                fuse_i,
   input  wire logic                     swap_start_i,
   input  wire logic                     mux_sel_i,
   output logic [7:0]                    gain_trim_o,
   output logic [3:0]                    reference_trim_o,
   output logic [NUM_INPUTS-1:0][7:0]    termination_trim_o,
   output logic                          swap_overlap_o,
   output logic                          mux_sel_o
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0]                   gain_q;
   logic [3:0]                   ref_q;
   logic [NUM_INPUTS-1:0][7:0]   term_q;
   logic [4:0]                   overlap_q;
   logic [4:0]                   seldly_q;
   logic                         load_q;
   logic                         ack_q;
   logic [31:0]                  rdat_q;
   logic                         wr_en;
   logic [9:0]                   idx;

   function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
      hit = (a == b);
   endfunction : hit

   assign idx   = wb_req_i.adr[11:2];
   assign wr_en = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !ack_q && wb_req_i.sel[0];

   // ----------------------------------------------------------------
   // wishbone: ack one cycle after request, dropped the next
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req_i.cyc && wb_req_i.stb && !ack_q;
      end
   end
   assign wb_ack_o = ack_q;

   // fuse values are caught on the first clock after reset release, not under reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_q <= 1'b1;
      end else begin
         load_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // trim registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_q <= 8'h00;
         ref_q  <= 4'h0;
      end else if (load_q) begin
         gain_q <= fuse_i.gain;
         ref_q  <= fuse_i.reference;
      end else if (wr_en) begin
         if (hit(idx, IDX_CORE_GAIN_TRIM)) gain_q <= wb_req_i.dat[7:0];
         if (hit(idx, IDX_REFERENCE_TRIM)) ref_q <= wb_req_i.dat[3:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_INPUTS; g++) begin : g_term
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               term_q[g] <= 8'h00;
            end else if (load_q) begin
               term_q[g] <= fuse_i.termination[g];
            end else if (wr_en && hit(idx, IDX_TERM_TRIM_A + 10'(g))) begin
               term_q[g] <= wb_req_i.dat[7:0];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // swap delay registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overlap_q <= SWAP_OVERLAP_RST;
         seldly_q  <= OUTPUT_SEL_DLY_RST;
      end else if (wr_en) begin
         // reserved bits are not stored; software writing defaults keeps them zero
         if (hit(idx, IDX_SWAP_OVERLAP)) overlap_q <= wb_req_i.dat[4:0];
         if (hit(idx, IDX_OUTPUT_SEL_DLY)) seldly_q <= wb_req_i.dat[4:0];
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !ack_q) begin
         rdat_q <= 32'h0000_0000;
         if (hit(idx, IDX_CORE_GAIN_TRIM)) rdat_q <= {24'h000000, gain_q};
         if (hit(idx, IDX_REFERENCE_TRIM)) rdat_q <= {28'h0000000, ref_q};
         for (int i = 0; i < NUM_INPUTS; i++) begin
            if (hit(idx, IDX_TERM_TRIM_A + 10'(i))) rdat_q <= {24'h000000, term_q[i]};
         end
         if (hit(idx, IDX_SWAP_OVERLAP)) rdat_q <= {27'h0000000, overlap_q};
         if (hit(idx, IDX_OUTPUT_SEL_DLY)) rdat_q <= {27'h0000000, seldly_q};
      end
   end
   assign wb_dat_o = rdat_q;

   // trims act on the analog controls directly, no commit stage
   assign gain_trim_o        = gain_q;
   assign reference_trim_o   = ref_q;
   assign termination_trim_o = term_q;

   // ----------------------------------------------------------------
   // background swap timing
   // ----------------------------------------------------------------
   logic [6:0]  ovl_cnt_q;
   logic [5:0]  sel_cnt_q;
   logic        sel_pend_q;
   logic        mux_q;

   // overlap window of 4 + 2*setting cycles; setting captured at swap start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovl_cnt_q <= 7'h00;
      end else if (swap_start_i) begin
         ovl_cnt_q <= OVERLAP_BASE_CYC + {1'b0, overlap_q, 1'b0};
      end else if (ovl_cnt_q != 7'h00) begin
         ovl_cnt_q <= ovl_cnt_q - 7'h01;
      end
   end
   assign swap_overlap_o = (ovl_cnt_q != 7'h00);

   // select change during a swap waits setting cycles; outside swaps it passes at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mux_q      <= 1'b0;
         sel_pend_q <= 1'b0;
         sel_cnt_q  <= 6'h00;
      end else if (swap_overlap_o && mux_sel_i != mux_q) begin
         if (!sel_pend_q) begin
            sel_pend_q <= 1'b1;
            sel_cnt_q  <= {1'b0, seldly_q};
            if (seldly_q == 5'h00) begin
               mux_q      <= mux_sel_i;
               sel_pend_q <= 1'b0;
            end
         end else if (sel_cnt_q <= 6'h01) begin
            mux_q      <= mux_sel_i;
            sel_pend_q <= 1'b0;
         end else begin
            sel_cnt_q <= sel_cnt_q - 6'h01;
         end
      end else begin
         mux_q      <= mux_sel_i;
         sel_pend_q <= 1'b0;
      end
   end
   assign mux_sel_o = mux_q;
endmodule : tsd_trim_and_swap_delay_regs

// ==== test/tsd_regs_monitor.sv ====
// checker: bus, trim load and swap timing of the register bank
`timescale 1ns/100ps
module tsd_regs_monitor
   import tsd_pkg::*;
(
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire tsd_wb_req_t                wb_req_i,
   input wire logic                       wb_ack_o,
   input wire logic [31:0]                wb_dat_o,
   input wire tsd_fuse_t                  fuse_i,
   input wire logic                       swap_start_i,
   input wire logic                       mux_sel_i,
   input wire logic [7:0]                 gain_trim_o,
   input wire logic [3:0]                 reference_trim_o,
   input wire logic [NUM_INPUTS-1:0][7:0] termination_trim_o,
   input wire logic                       swap_overlap_o,
   input wire logic                       mux_sel_o
);
   // ------
   // relations
   // ------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence
   sequence s_wr(logic [9:0] i);
      s_take ##0 (wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == {i, 2'b00});
   endsequence
   a_ack_next: assert property (s_take |=> wb_ack_o) else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   // fuse struct order matches the output concatenation
   a_fuse_load: assert property ($fell(rst_i) |-> ##2
      {gain_trim_o, reference_trim_o, termination_trim_o} == fuse_i) else $error("fuse");
   a_gain_write: assert property (s_wr(IDX_CORE_GAIN_TRIM) |=>
      gain_trim_o == $past(wb_req_i.dat[7:0])) else $error("gain write");
   a_ref_write: assert property (s_wr(IDX_REFERENCE_TRIM) |=>
      reference_trim_o == $past(wb_req_i.dat[3:0])) else $error("ref write");
   a_term_write: assert property (s_wr(IDX_TERM_TRIM_D) |=>
      termination_trim_o[3] == $past(wb_req_i.dat[7:0])) else $error("term write");
   a_read_gain: assert property (s_take ##0 (!wb_req_i.we && wb_req_i.adr == 12'h1e8) |=>
      wb_dat_o == {24'h0, gain_trim_o}) else $error("gain read");
   a_swap_min: assert property (swap_start_i && !swap_overlap_o |=>
      swap_overlap_o [*4]) else $error("overlap short");
   a_mux_follow: assert property (!swap_overlap_o [*3] |->
      mux_sel_o == $past(mux_sel_i)) else $error("mux late");
endmodule : tsd_regs_monitor
bind tsd_trim_and_swap_delay_regs tsd_regs_monitor u_mon (.clk_i, .rst_i, .wb_req_i,
   .wb_ack_o, .wb_dat_o, .fuse_i, .swap_start_i, .mux_sel_i, .gain_trim_o,
   .reference_trim_o, .termination_trim_o, .swap_overlap_o, .mux_sel_o);

// ==== test/tb_trim_and_swap_delay_regs.sv ====
// testbench: register bank against a behavioural model
`timescale 1ns/100ps
module tb_trim_and_swap_delay_regs
   import tsd_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, swap_start_i = 1'b0, mux_sel_i = 1'b0;
   logic        wb_ack_o, swap_overlap_o, mux_sel_o;
   logic [31:0] wb_dat_o, rd;
   logic [7:0]  gain_trim_o;
   logic [3:0]  reference_trim_o;
   logic [31:0] term_o;
   tsd_wb_req_t req = '0;
   tsd_fuse_t   fz;
   int          err_total = 0, num_checks = 0, m[8], n, md, d;
   logic [9:0]  ix[8] = '{IDX_CORE_GAIN_TRIM, IDX_REFERENCE_TRIM, IDX_TERM_TRIM_A,
      IDX_TERM_TRIM_B, IDX_TERM_TRIM_C, IDX_TERM_TRIM_D, IDX_SWAP_OVERLAP, IDX_OUTPUT_SEL_DLY};
   logic [7:0]  mk[8] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f};
   always #2 clk_i = ~clk_i;
   tsd_trim_and_swap_delay_regs u_tsd_trim_and_swap_delay_regs (.clk_i, .rst_i,
      .wb_req_i(req), .wb_ack_o, .wb_dat_o, .fuse_i(fz), .swap_start_i, .mux_sel_i,
      .gain_trim_o, .reference_trim_o, .termination_trim_o(term_o), .swap_overlap_o,
      .mux_sel_o);
   // ------
   // tasks
   // ------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [43:0] s, input logic [43:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   // request held until ack is sampled, released on that same edge
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] v);
      int t;
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, w, {a, 2'b00}, 4'h1, {24'h0, v}};
      for (t = 0; t < 50 && wb_ack_o !== 1'b1; t++) @(posedge clk_i);
      if (t == 50) begin
         err_total++;
         end_of_test;
      end
      rd = wb_dat_o;
      req <= '0;
   endtask : wb
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      m = '{fz.gain, fz.reference, fz.termination[0], fz.termination[1], fz.termination[2],
         fz.termination[3], SWAP_OVERLAP_RST, OUTPUT_SEL_DLY_RST};
      repeat (3) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         wb(1'b0, ix[k], 8'h00);
         chk(rd, m[k]);
      end
   endtask : do_reset
   // ------
   // sequence
   // ------
   initial begin
      void'($urandom(67));
      fz = tsd_fuse_t'(44'({$urandom, $urandom}));
      do_reset;
      for (int k = 0; k < 8; k++) begin
         m[k] = $urandom & mk[k];
         wb(1'b1, ix[k], m[k][7:0]);
         wb(1'b0, ix[k], 8'h00);
         chk(rd, m[k]);
      end
      chk({gain_trim_o, reference_trim_o, term_o}, {m[0][7:0], m[1][3:0], m[5][7:0],
         m[4][7:0], m[3][7:0], m[2][7:0]});
      wb(1'b1, 10'h07b, 8'h5a);
      wb(1'b0, 10'h07b, 8'h00);
      chk(rd, 0);
      d = $urandom_range(31);
      wb(1'b1, IDX_OUTPUT_SEL_DLY, d[7:0]);
      // overlap settings 0, 7 (slow clock choice) and 31
      for (int v = 0; v < 32; v = (v == 0) ? 7 : v + 24) begin
         wb(1'b1, IDX_SWAP_OVERLAP, v[7:0]);
         @(posedge clk_i) swap_start_i <= 1'b1;
         @(posedge clk_i) swap_start_i <= 1'b0;
         md = -1;
         for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (swap_overlap_o !== 1'b1) break;
            if (n == 2 && v == 31) mux_sel_i <= ~mux_sel_i;
            if (md < 0 && n > 2 && v == 31 && mux_sel_o === mux_sel_i) md = n - 3;
         end
         chk(n, 4 + 2 * v);
         // one register stage plus the programmed delay; only the long window holds it all
         if (v == 31) chk(md, d + 1);
      end
      repeat (8) @(posedge clk_i) mux_sel_i <= 1'($urandom);
      do_reset;
      end_of_test;
   end
endmodule : tb_trim_and_swap_delay_regs
